//--- hw/asc_core.sv
// asc_core.sv: scan sequencer and control register of the 12-bit converter
// assumes: inputs synchronous to sys_clk; converter core answers each request with one done pulse
`timescale 1ns/10ps
`include "asc_map.svh"

// How it works
// R1 - duplication field picks channel 0 to 7
// R2 - first trigger normal, second duplication register
// R3 - double mode converts only duplication channel
// R4 - double behaviour applies to group A only
// R5 - double hardware start interrupts after second
// R6 - software start interrupts at scan end
// R7 - group B interrupt gated by bit 6
// R8 - bit 8 picks sync or async
// R9 - triggers accepted only with bit 9
// R10 - bit 12 gates main scan end interrupt
// R11 - mode field: single, group, continuous
// R12 - single scan converts ascending, then stops
// R13 - continuous repeats; cleared start aborts at once
// R14 - each group one ascending pass per trigger
// R15 - software keeps groups distinct
// R16 - empty selection in single converts reference
// R17 - start set by software or A trigger
// R18 - start set by B or async trigger
// R19 - priority mode sets start three ways
// R20 - async start on armed falling edge
// R21 - external pin low at least 1.5 cycles
// R22 - double mode only with group A trigger
// R23 - mode fields change only while stopped; the code takes writes to them at any time, mid-scan too
// R24 - reserved bits read zero
// R25 - start clears when scan finishes
// R26 - interrupts are one-cycle pulses
module asc_core #(
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // group settings held elsewhere
  input wire logic [NCH-1:0] first_group_channel_sel,
  input wire logic [NCH-1:0] second_group_channel_sel,
  input wire logic [NCH-1:0] third_group_channel_sel,
  input wire logic third_group_en,
  input wire logic group_priority_en,
  input wire logic low_priority_rescan_en,
  input wire logic single_scan_continuous_en,
  // triggers
  input wire logic first_group_trigger,
  input wire logic second_group_trigger,
  input wire logic third_group_trigger,
  input wire logic external_trigger_pin_n,
  // converter core
  output logic conv_req,
  output logic [2:0] conv_channel,
  output logic conv_ref,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // results and events
  output asc_pkg::asc_result_t result,
  output logic scan_end_interrupt,
  output logic second_group_end_interrupt,
  output logic conversion_start_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] asc_lowest(input logic [NCH-1:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : asc_lowest

  function automatic logic [15:0] asc_pack(input asc_pkg::asc_ctrl_t c);
    logic [15:0] v;
    v = 16'h0000; // R24
    v[`ASC_DUP_MSB:`ASC_DUP_LSB] = c.dup_ch;
    v[`ASC_GRPB_IRQ_BIT] = c.grpb_irq_en;
    v[`ASC_DBL_BIT] = c.dbl_en;
    v[`ASC_TRG_SEL_BIT] = c.trg_sel;
    v[`ASC_TRG_EN_BIT] = c.trg_en;
    v[`ASC_IRQ_EN_BIT] = c.irq_en;
    v[`ASC_MODE_MSB:`ASC_MODE_LSB] = c.mode;
    v[`ASC_START_BIT] = c.start;
    return v;
  endfunction : asc_pack

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam logic [15:0] CTRL_RESET = `ASC_CTRL_RESET;
  localparam asc_pkg::asc_state_t ST_RESET = '{
    ctrl: '{
      start: CTRL_RESET[`ASC_START_BIT],
      mode: CTRL_RESET[`ASC_MODE_MSB:`ASC_MODE_LSB],
      irq_en: CTRL_RESET[`ASC_IRQ_EN_BIT],
      trg_en: CTRL_RESET[`ASC_TRG_EN_BIT],
      trg_sel: CTRL_RESET[`ASC_TRG_SEL_BIT],
      dbl_en: CTRL_RESET[`ASC_DBL_BIT],
      grpb_irq_en: CTRL_RESET[`ASC_GRPB_IRQ_BIT],
      dup_ch: CTRL_RESET[`ASC_DUP_MSB:`ASC_DUP_LSB]
    },
    phase: asc_pkg::asc_idle,
    group: asc_pkg::asc_grp_a,
    pin_prev: 1'b1,
    default: '0
  };

  asc_pkg::asc_state_t st_reg;
  asc_pkg::asc_state_t st_next;
  logic [NCH-1:0] dup_onehot;
  logic [NCH-1:0] mask_a;
  logic [NCH-1:0] mask_b;
  logic [NCH-1:0] mask_c;
  logic is_group;
  logic prio;

  // duplication channel as a one-hot selection
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_dup
      assign dup_onehot[g] = (st_reg.ctrl.dup_ch == 5'(g)); // R1
    end
  endgenerate

  assign is_group = (st_reg.ctrl.mode == `ASC_MODE_GROUP);
  assign prio = is_group & group_priority_en;
  assign mask_a = st_reg.ctrl.dbl_en ? dup_onehot : first_group_channel_sel; // R3
  assign mask_b = second_group_channel_sel; // R4
  assign mask_c = third_group_channel_sel;

  always_comb begin
    logic wr_hit;
    logic trig_a;
    logic ext_edge;
    logic trig_b;
    logic trig_c;
    logic [2:0] new_req;
    logic start_any;
    asc_pkg::asc_group_t sg;
    logic [NCH-1:0] sm;
    logic s_sw;
    logic [NCH-1:0] left;
    logic dbl_hw;
    wr_hit = 1'b0;
    trig_a = 1'b0;
    ext_edge = 1'b0;
    trig_b = 1'b0;
    trig_c = 1'b0;
    new_req = 3'h0;
    start_any = 1'b0;
    sg = asc_pkg::asc_grp_a;
    sm = '0;
    s_sw = 1'b0;
    left = '0;
    dbl_hw = 1'b0;
    st_next = st_reg;
    st_next.irq = 1'b0; // R26
    st_next.irq_b = 1'b0;
    st_next.conv_req = 1'b0;
    st_next.res.we = 1'b0;
    st_next.pin_prev = external_trigger_pin_n;

    // ----------------------------------------
    // register port
    // ----------------------------------------
    wr_hit = reg_write && (reg_addr == `ASC_CTRL_OFFSET);
    st_next.rd = (reg_read && (reg_addr == `ASC_CTRL_OFFSET)) ? asc_pack(st_reg.ctrl) : 16'h0000;
    if (wr_hit) begin
      st_next.ctrl.dup_ch = reg_wdata[`ASC_DUP_MSB:`ASC_DUP_LSB];
      st_next.ctrl.grpb_irq_en = reg_wdata[`ASC_GRPB_IRQ_BIT];
      st_next.ctrl.dbl_en = reg_wdata[`ASC_DBL_BIT];
      st_next.ctrl.trg_sel = reg_wdata[`ASC_TRG_SEL_BIT];
      st_next.ctrl.trg_en = reg_wdata[`ASC_TRG_EN_BIT];
      st_next.ctrl.irq_en = reg_wdata[`ASC_IRQ_EN_BIT];
      st_next.ctrl.mode = reg_wdata[`ASC_MODE_MSB:`ASC_MODE_LSB]; // R11
      if (!reg_wdata[`ASC_START_BIT]) begin
        // clearing start stops everything at once, even mid-scan
        st_next.ctrl.start = 1'b0; // R13
        st_next.phase = asc_pkg::asc_idle;
        st_next.pend = '0;
        st_next.req = 3'h0;
      end else if (st_reg.phase == asc_pkg::asc_idle) begin
        start_any = 1'b1; // R17
        s_sw = 1'b1;
        sg = asc_pkg::asc_grp_a;
      end
    end

    // ----------------------------------------
    // triggers
    // ----------------------------------------
    // the pin arms only while high with async start selected
    if (!(st_reg.ctrl.trg_en && st_reg.ctrl.trg_sel)) begin
      st_next.armed = 1'b0;
    end else if (external_trigger_pin_n) begin
      st_next.armed = 1'b1; // R20
    end
    ext_edge = st_reg.armed & st_reg.pin_prev & ~external_trigger_pin_n; // R20
    trig_a = st_reg.ctrl.trg_en & (st_reg.ctrl.trg_sel ? ext_edge : first_group_trigger); // R8 R9
    trig_b = st_reg.ctrl.trg_en & is_group & second_group_trigger; // R9 R18
    trig_c = st_reg.ctrl.trg_en & is_group & third_group_en & third_group_trigger; // R14
    new_req = {trig_c, trig_b, trig_a};

    if (!start_any && (new_req != 3'h0)) begin
      if (st_reg.phase == asc_pkg::asc_idle && st_next.phase == asc_pkg::asc_idle && !wr_hit) begin
        start_any = 1'b1; // R17 R18 R19
        sg = trig_a ? asc_pkg::asc_grp_a : (trig_b ? asc_pkg::asc_grp_b : asc_pkg::asc_grp_c);
        st_next.req = st_reg.req | (new_req & ~{trig_c & (trig_a | trig_b), trig_b & trig_a, trig_a});
        st_next.req = prio ? st_next.req : 3'h0;
      end else if (prio && st_next.phase == asc_pkg::asc_busy) begin
        st_next.req = st_next.req | new_req;
      end
    end

    // ----------------------------------------
    // conversion done
    // ----------------------------------------
    if (st_reg.phase == asc_pkg::asc_busy && st_next.phase == asc_pkg::asc_busy && conv_done) begin
      dbl_hw = (st_reg.group == asc_pkg::asc_grp_a) && st_reg.ctrl.dbl_en && !st_reg.sw_start;
      st_next.res.we = 1'b1;
      st_next.res.channel = st_reg.conv_ch;
      st_next.res.is_ref = st_reg.ref_conv; // R16
      st_next.res.to_dup = dbl_hw && st_reg.dbl_second; // R2
      st_next.res.data = conv_result;
      left = st_reg.ref_conv ? '0 : (st_reg.pend & ~(NCH'(1) << st_reg.conv_ch));
      st_next.pend = left;
      if (prio && st_reg.req[0] && st_reg.group != asc_pkg::asc_grp_a) begin
        // group A preempts a lower group between conversions
        st_next.phase = asc_pkg::asc_idle;
        if (low_priority_rescan_en) begin
          st_next.req[st_reg.group] = 1'b1;
        end
      end else if (left != '0) begin
        st_next.conv_req = 1'b1; // R12 R14
        st_next.conv_ch = asc_lowest(left);
      end else begin
        // end of one pass
        if (st_reg.group != asc_pkg::asc_grp_a && is_group) begin
          st_next.irq_b = st_reg.ctrl.grpb_irq_en; // R7
        end else if (dbl_hw) begin
          st_next.irq = st_reg.ctrl.irq_en & st_reg.dbl_second; // R5
          st_next.dbl_second = ~st_reg.dbl_second; // R2
        end else begin
          st_next.irq = st_reg.ctrl.irq_en; // R6 R10
        end
        if (st_reg.ctrl.mode == `ASC_MODE_CONT) begin
          st_next.pend = mask_a; // R13
          st_next.conv_req = 1'b1;
          st_next.conv_ch = asc_lowest(mask_a);
        end else begin
          st_next.phase = asc_pkg::asc_idle;
          st_next.ctrl.start = 1'b0; // R25
        end
      end
      // a pending or lowest-priority restart follows the finished scan
      if (prio && st_next.phase == asc_pkg::asc_idle) begin
        if (st_next.req == 3'h0 && single_scan_continuous_en) begin
          st_next.req[third_group_en ? 2 : 1] = 1'b1; // R19
        end
      end
    end

    // ----------------------------------------
    // serve queued group requests, highest priority first
    // ----------------------------------------
    if (!start_any && prio && st_next.phase == asc_pkg::asc_idle && st_next.req != 3'h0 && !wr_hit) begin
      start_any = 1'b1; // R19
      sg = st_next.req[0] ? asc_pkg::asc_grp_a : (st_next.req[1] ? asc_pkg::asc_grp_b : asc_pkg::asc_grp_c);
      st_next.req[sg] = 1'b0;
    end

    // ----------------------------------------
    // scan start
    // ----------------------------------------
    if (start_any) begin
      unique case (sg)
        asc_pkg::asc_grp_a: sm = mask_a;
        asc_pkg::asc_grp_b: sm = mask_b;
        asc_pkg::asc_grp_c: sm = mask_c;
        default: sm = '0;
      endcase
      st_next.ctrl.start = 1'b1; // R17 R18
      st_next.phase = asc_pkg::asc_busy;
      st_next.group = sg;
      st_next.sw_start = s_sw;
      st_next.pend = sm;
      st_next.ref_conv = (sg == asc_pkg::asc_grp_a) && (sm == '0)
        && (st_reg.ctrl.mode == `ASC_MODE_SINGLE); // R16
      st_next.conv_req = 1'b1; // R12
      st_next.conv_ch = asc_lowest(sm);
      if (sm == '0 && !st_next.ref_conv) begin
        // nothing to convert: the pass is over at once
        st_next.phase = asc_pkg::asc_idle;
        st_next.conv_req = 1'b0;
        st_next.ctrl.start = 1'b0; // R25
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = st_reg.rd;
  assign conv_req = st_reg.conv_req;
  assign conv_channel = st_reg.conv_ch;
  assign conv_ref = st_reg.ref_conv;
  assign result = st_reg.res;
  assign scan_end_interrupt = st_reg.irq;
  assign second_group_end_interrupt = st_reg.irq_b;
  assign conversion_start_out = st_reg.ctrl.start;

endmodule : asc_core

//--- include/asc_map.svh
// asc_map.svh: offsets, field positions, reset values and codes of the scan control block
// assumes: included by the scan control package users only
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_CTRL_OFFSET 32'h0008_9000
`define ASC_DUP_LSB 0
`define ASC_DUP_MSB 4
`define ASC_GRPB_IRQ_BIT 6
`define ASC_DBL_BIT 7
`define ASC_TRG_SEL_BIT 8
`define ASC_TRG_EN_BIT 9
`define ASC_IRQ_EN_BIT 12
`define ASC_MODE_LSB 13
`define ASC_MODE_MSB 14
`define ASC_START_BIT 15
`define ASC_CTRL_RESET 16'h0000
`define ASC_MODE_SINGLE 2'h0
`define ASC_MODE_GROUP 2'h1
`define ASC_MODE_CONT 2'h2
`endif

//--- include/asc_pkg.sv
// asc_pkg.sv: types of the scan control block
// assumes: nothing
package asc_pkg;
  typedef enum logic {asc_idle, asc_busy} asc_phase_t;
  typedef enum logic [1:0] {asc_grp_a, asc_grp_b, asc_grp_c} asc_group_t;

  // software visible control fields
  typedef struct packed {
    logic start;
    logic [1:0] mode;
    logic irq_en;
    logic trg_en;
    logic trg_sel;
    logic dbl_en;
    logic grpb_irq_en;
    logic [4:0] dup_ch;
  } asc_ctrl_t;

  // one finished conversion toward the data registers
  typedef struct packed {
    logic we;
    logic [2:0] channel;
    logic to_dup;
    logic is_ref;
    logic [11:0] data;
  } asc_result_t;

  // whole block state
  typedef struct packed {
    asc_ctrl_t ctrl;
    asc_phase_t phase;
    asc_group_t group;
    logic [7:0] pend;
    logic ref_conv;
    logic sw_start;
    logic dbl_second;
    logic pin_prev;
    logic armed;
    logic [2:0] req;
    logic irq;
    logic irq_b;
    logic conv_req;
    logic [2:0] conv_ch;
    asc_result_t res;
    logic [15:0] rd;
  } asc_state_t;
endpackage : asc_pkg

//--- tb/asc_conv_model.sv
// asc_conv_model.sv: behavioural conversion core behind the scan control block
// assumes: one request at a time; answers after dly cycles, dly at least 1
`timescale 1ns/10ps
module asc_conv_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // answer delay
  input wire logic [3:0] dly,
  // request and answer
  input wire logic conv_req,
  input wire logic [2:0] conv_channel,
  output logic conv_done,
  output logic [11:0] conv_result
);
  logic [3:0] cnt_reg;
  logic [11:0] last_reg;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      last_reg <= 12'h000;
      conv_done <= 1'b0;
      conv_result <= 12'hFFF;
    end else begin
      conv_done <= 1'b0;
      // outside the answer cycle the bus shows the inverse of the last value
      conv_result <= ~last_reg;
      if (conv_req) begin
        cnt_reg <= dly;
      end else if (cnt_reg == 4'h1) begin
        cnt_reg <= 4'h0;
        conv_done <= 1'b1;
        conv_result <= {9'h155, conv_channel};
        last_reg <= {9'h155, conv_channel};
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : asc_conv_model

//--- tb/asc_core_sva.sv
// asc_core_sva.sv: port checks of the scan control block
// assumes: bound to asc_core, single clock domain
`timescale 1ns/10ps
`include "asc_map.svh"
module asc_core_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // converter and events
  input wire logic conv_req,
  input wire logic conv_done,
  input wire asc_pkg::asc_result_t result,
  input wire logic scan_end_interrupt,
  input wire logic second_group_end_interrupt,
  input wire logic conversion_start_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic hit = reg_addr == `ASC_CTRL_OFFSET;
  property p_rsv; reg_read && hit |=> reg_rdata[5] == 1'b0 && reg_rdata[11:10] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_rd_start; reg_read && hit |=> reg_rdata[15] == $past(conversion_start_out); endproperty
  a_rd_start: assert property (p_rd_start) else $error("start bit readback wrong");
  property p_sw_start; reg_write && hit && reg_wdata[15] && !conversion_start_out |=> conversion_start_out && conv_req;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored");
  property p_sw_stop; reg_write && hit && !reg_wdata[15] |=> !conversion_start_out && !conv_req; endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("stop did not abort");
  property p_irq_pulse; scan_end_interrupt |=> !scan_end_interrupt; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("scan end pulse too long");
  property p_irqb; second_group_end_interrupt |-> !scan_end_interrupt ##1 !second_group_end_interrupt; endproperty
  a_irqb: assert property (p_irqb) else $error("group end pulse wrong");
  property p_irq_cause; scan_end_interrupt |-> $past(conv_done); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("scan end without conversion");
  property p_we_cause; result.we |-> $past(conv_done) && !$past(result.we); endproperty
  a_we_cause: assert property (p_we_cause) else $error("result without conversion");
  property p_req_gap; conv_req |=> !conv_req; endproperty
  a_req_gap: assert property (p_req_gap) else $error("requests back to back");
  property p_idle; !conversion_start_out |-> !conv_req; endproperty
  a_idle: assert property (p_idle) else $error("request while stopped");
  c_irq: cover property (scan_end_interrupt);
  c_dup: cover property (result.we && result.to_dup);
  c_grpb: cover property (second_group_end_interrupt);
endmodule : asc_core_sva
bind asc_core asc_core_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_req(conv_req), .conv_done(conv_done),
  .result(result), .scan_end_interrupt(scan_end_interrupt), .second_group_end_interrupt(second_group_end_interrupt),
  .conversion_start_out(conversion_start_out));

//--- tb/tb_top.sv
// tb_top.sv: self-checking bench of the scan control block
// assumes: behavioural conversion core on the far side
`timescale 1ns/10ps
`include "asc_map.svh"
module tb_top;
  localparam logic [31:0] OFS = `ASC_CTRL_OFFSET;
  typedef struct packed {logic [15:0] w; logic [15:0] r; logic [7:0] m; logic [11:0] c;} asc_row_t;
  logic sys_clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, pin = 1'b1, tc = 1'b0;
  logic [31:0] reg_addr = OFS;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic [7:0] fa = 8'h00, fb = 8'h00, fc = 8'h00;
  logic [2:0] trg = 3'b000, conv_channel;
  logic conv_req, conv_ref, conv_done, irq, irqb, start;
  logic [11:0] conv_result, chs = 12'h000;
  logic [3:0] dly = 4'h1;
  logic [1:0] dups = 2'b00;
  asc_pkg::asc_result_t result;
  int mismatches = 0, n_checks = 0, nreq = 0, nirq = 0, nirqb = 0, nref = 0, sr, si, sb, sf;
  // mode codes 00, 01, 10 only
  asc_row_t rows [4] = '{'{16'h0000, 16'h0000, 8'hA4, 12'hADF}, '{16'h1FFF, 16'h13DF, 8'h07, 12'h89A},
    '{16'h3F3F, 16'h331F, 8'hE0, 12'hDEF}, '{16'h4020, 16'h4000, 8'h49, 12'h8BE}};
  always #2 sys_clk = ~sys_clk;
  asc_core #(.NCH(8)) DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .first_group_channel_sel(fa),
    .second_group_channel_sel(fb), .third_group_channel_sel(fc), .third_group_en(tc), .group_priority_en(1'b0),
    .low_priority_rescan_en(1'b0), .single_scan_continuous_en(1'b0), .first_group_trigger(trg[0]),
    .second_group_trigger(trg[1]), .third_group_trigger(trg[2]), .external_trigger_pin_n(pin),
    .conv_req(conv_req), .conv_channel(conv_channel), .conv_ref(conv_ref), .conv_done(conv_done),
    .conv_result(conv_result), .result(result), .scan_end_interrupt(irq), .second_group_end_interrupt(irqb),
    .conversion_start_out(start));
  asc_conv_model CORE (.sys_clk(sys_clk), .rstn(rstn), .dly(dly), .conv_req(conv_req),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_result(conv_result));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // request log: one nibble per request, marker bit above the channel
  always @(negedge sys_clk) begin
    if (conv_req === 1'b1) chs <= {chs[7:0], 1'b1, conv_channel};
    if (result.we === 1'b1) dups <= {dups[0], result.to_dup};
    if (result.we === 1'b1 && result.is_ref === 1'b0) chk(result.data, {9'h155, result.channel});
    nreq <= nreq + int'(conv_req === 1'b1);
    nirq <= nirq + int'(irq === 1'b1);
    nirqb <= nirqb + int'(irqb === 1'b1);
    nref <= nref + int'(result.we === 1'b1 && result.is_ref === 1'b1);
  end
  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [15:0] v, input logic [31:0] a = OFS);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic tp(input logic [2:0] t);
    @(posedge sys_clk);
    trg <= t;
    @(posedge sys_clk);
    trg <= 3'b000;
  endtask : tp
  task automatic mark;
    sr = nreq;
    si = nirq;
    sb = nirqb;
    sf = nref;
  endtask : mark
  task automatic fin;
    int i;
    i = 0;
    #1;
    while (start !== 1'b0 && i < 400) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk(i < 400, 1'b1);
    repeat (3) @(posedge sys_clk);
  endtask : fin
  task automatic ck(input logic [27:0] e);
    chk({chs, 4'(nreq - sr), 4'(nirq - si), 4'(nirqb - sb), 4'(nref - sf)}, {4'h0, e});
  endtask : ck
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].w);
      rd(OFS, d);
      chk(d, rows[k].r);
      wr(16'h1000);
      fa <= rows[k].m;
      mark();
      wr(16'h9000);
      fin();
      ck({rows[k].c, 16'h3100});
    end
    fa <= 8'h00;
    mark();
    wr(16'h9000);
    fin();
    chk({4'(nreq - sr), 4'(nref - sf), 4'(nirq - si)}, 12'h111);
    rd(OFS + 32'h4, d);
    chk(d, 16'h0000);
    wr(16'h9000, OFS + 32'h2);
    #1 chk(start, 1'b0);
    wr(16'h0000);
    fa <= 8'h07;
    tp(3'b001);
    #1 chk(start, 1'b0);
    wr(16'h0200);
    mark();
    tp(3'b001);
    fin();
    ck(28'h89A_3000);
    fa <= 8'h03;
    mark();
    wr(16'hC000);
    repeat (12) @(posedge sys_clk);
    wr(16'h0000);
    #1 chk(start, 1'b0);
    chk(nreq - sr > 2, 1'b1);
    mark();
    repeat (10) @(posedge sys_clk);
    chk(nreq - sr, 0);
    fa <= 8'h07;
    fb <= 8'h70;
    fc <= 8'h0B;
    tc <= 1'b1;
    wr(16'h2340);
    mark();
    tp(3'b010);
    fin();
    ck(28'hCDE_3010);
    wr(16'h2200);
    mark();
    tp(3'b100);
    fin();
    ck(28'h89B_3000);
    wr(16'h3200);
    mark();
    tp(3'b001);
    fin();
    ck(28'h89A_3100);
    wr(16'h0300);
    mark();
    @(posedge sys_clk);
    pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    pin <= 1'b1;
    fin();
    ck(28'h89A_3000);
    mark();
    dly <= 4'h5;
    wr(16'h1287);
    mark();
    mark();
    tp(3'b001);
    fin();
    chk(nirq - si, 0);
    tp(3'b001);
    fin();
    ck(28'hAFF_2100);
    chk(dups, 2'b01);
    mark();
    wr(16'h9287);
    fin();
    ck(28'hFFF_1100);
    dly <= 4'h1;
    wr(16'hC000);
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b0;
    #1 chk({start, conv_req, irq, reg_rdata}, 19'h0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    rd(OFS, d);
    chk(d, `ASC_CTRL_RESET);
    tally_and_finish();
  end
endmodule : tb_top
